// File: core/itp_counter.sv
`timescale 1ns/1ps
module itp_counter
	import itp_pkg::*;
(
	// system
	input wire logic ref_clk,
	input wire logic nrst,
	// programming
	input wire logic cw_wr,
	input wire logic [5:0] cw_val,
	input wire logic load_en,
	input wire logic [15:0] load_val,
	input wire logic latch_cmd,
	// pins
	input wire logic tick_in,
	input wire logic gate_in,
	// state
	output logic [15:0] count_view,
	output logic wave_out
);
	logic [5:0] cw_ff;
	logic [15:0] cnt_ff, reload_ff, latch_ff;
	logic latched_ff, tick_d_ff, gate_d_ff, out_ff, trig_ff;
	logic fresh_ff;
	logic [15:0] live_view;
	itp_phase_t ph_ff;
	logic tick_edge, gate_rise;
	logic [2:0] mode;
	logic [15:0] nxt_cnt;
	logic [15:0] dec_step;
	assign tick_edge = tick_in & ~tick_d_ff;
	assign gate_rise = gate_in & ~gate_d_ff;
	assign mode = {cw_ff[ITP_CW_MODE_LSB+2] & ~cw_ff[ITP_CW_MODE_LSB+1], cw_ff[ITP_CW_MODE_LSB+1:ITP_CW_MODE_LSB]};
	// mode 3 steps by two to make a half period
	assign dec_step = (mode == 3'd3) ? 16'h0002 : 16'h0001;
	always_comb begin
		nxt_cnt = cnt_ff - dec_step;
		if (cw_ff[ITP_CW_BCD_BIT] && cnt_ff[3:0] < dec_step[3:0]) begin
			nxt_cnt = cnt_ff - dec_step - 16'h0006;
			if (cnt_ff[7:4] == 4'h0)
				nxt_cnt = nxt_cnt - 16'h0060;
			if (cnt_ff[11:4] == 8'h00)
				nxt_cnt = nxt_cnt - 16'h0600;
			if (cnt_ff[15:4] == 12'h000)
				nxt_cnt = nxt_cnt - 16'h6000;
		end
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tick_d_ff <= 1'b0;
			gate_d_ff <= 1'b0;
		end else begin
			tick_d_ff <= tick_in;
			gate_d_ff <= gate_in;
		end
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cw_ff <= ITP_CW_RST;
		end else if (cw_wr) begin
			cw_ff <= cw_val;
		end
	end
	// own clock only: advances on its tick edge
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= ITP_CNT_RST;
			reload_ff <= ITP_CNT_RST;
			ph_ff <= ITP_IDLE;
			out_ff <= 1'b0;
			trig_ff <= 1'b0;
			fresh_ff <= 1'b1;
		end else if (cw_wr) begin
			cnt_ff <= ITP_CNT_RST;
			fresh_ff <= 1'b1;
			ph_ff <= ITP_IDLE;
			out_ff <= (cw_val[ITP_CW_MODE_LSB+2:ITP_CW_MODE_LSB] != 3'd0);
			trig_ff <= 1'b0;
		end else begin
			if (load_en) begin
				reload_ff <= load_val;
				if (ph_ff == ITP_IDLE)
					ph_ff <= ITP_ARMED;
				if (mode == 3'd0)
					out_ff <= 1'b0;
			end else if (tick_edge) begin
				case (ph_ff)
				ITP_ARMED: begin
					// hardware triggered modes wait for a gate rise
					if (!(mode == 3'd1 || mode == 3'd5) || trig_ff) begin
						cnt_ff <= (mode == 3'd3) ? {reload_ff[15:1], 1'b0} : reload_ff;
						ph_ff <= ITP_RUN;
						fresh_ff <= 1'b0;
						trig_ff <= 1'b0;
						if (mode == 3'd1)
							out_ff <= 1'b0;
					end
				end
				ITP_RUN: begin
					if ((mode == 3'd1 || mode == 3'd5) && trig_ff) begin
						cnt_ff <= reload_ff;
						trig_ff <= 1'b0;
					end else if (gate_in || mode == 3'd1 || mode == 3'd5) begin
						cnt_ff <= nxt_cnt;
						// output shaping per mode
						case (mode)
						3'd0, 3'd1: if (cnt_ff == 16'h0001) out_ff <= 1'b1;
						3'd2: begin
							out_ff <= (cnt_ff != 16'h0002);
							if (cnt_ff == 16'h0001) cnt_ff <= reload_ff;
						end
						3'd3: if (cnt_ff == 16'h0002) begin
							out_ff <= ~out_ff;
							cnt_ff <= {reload_ff[15:1], 1'b0};
						end
						3'd4, 3'd5: begin
							out_ff <= (cnt_ff != 16'h0001);
							if (cnt_ff == 16'h0000) ph_ff <= ITP_IDLE;
						end
						default: out_ff <= out_ff;
						endcase
					end
				end
				default: ph_ff <= ph_ff;
				endcase
			end
			// last assignment: a trigger landing with its consumer survives
			if (gate_rise)
				trig_ff <= 1'b1;
		end
	end
	// snapshot freezes the readable view until the next control word or count load
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			latch_ff <= ITP_CNT_RST;
			latched_ff <= 1'b0;
		end else if (cw_wr) begin
			latched_ff <= 1'b0;
		end else if (latch_cmd && !latched_ff) begin
			latch_ff <= live_view;
			latched_ff <= 1'b1;
		end else if (load_en) begin
			latched_ff <= 1'b0;
		end
	end
	// cleared element stays hidden behind the held count until the armed element takes its count on a tick edge
	assign live_view = fresh_ff ? reload_ff : cnt_ff;
	assign count_view = latched_ff ? latch_ff : live_view;
	assign wave_out = out_ff;
endmodule

// File: core/itp_host_port.sv
`timescale 1ns/1ps
module itp_host_port
	import itp_pkg::*;
(
	// system
	ref_clk,
	nrst,
	// processor bus
	chip_sel_n,
	rd_n,
	wr_n,
	port_select_lines,
	data_in,
	data_out,
	data_oe,
	// counter pins
	counter_tick_inputs,
	count_enable_inputs,
	timer_wave_pins
);
	input wire logic ref_clk;
	input wire logic nrst;
	input wire logic chip_sel_n;
	input wire logic rd_n;
	input wire logic wr_n;
	input wire logic [1:0] port_select_lines;
	input wire logic [ITP_DATA_W-1:0] data_in;
	output logic [ITP_DATA_W-1:0] data_out;
	output logic data_oe;
	input wire logic [ITP_NUM_CNT-1:0] counter_tick_inputs;
	input wire logic [ITP_NUM_CNT-1:0] count_enable_inputs;
	output logic [ITP_NUM_CNT-1:0] timer_wave_pins;

	////////////////////////////////////////////////////////////////////////////////
	logic [ITP_NUM_CNT-1:0] wave;
	logic [15:0] view [ITP_NUM_CNT];
	logic [1:0] fmt_ff [ITP_NUM_CNT];
	logic [ITP_NUM_CNT-1:0] wr_hi_ff, rd_hi_ff, cw_wr, load_en, latch_cmd;
	logic [7:0] lo_hold_ff [ITP_NUM_CNT];
	logic [15:0] load_val [ITP_NUM_CNT];
	logic wr_d_ff, rd_d_ff, wr_edge, rd_edge, sel, rd_act;
	logic [7:0] nxt_data;
	logic [1:0] sc;
	logic [1:0] tgt;

	assign sel = ~chip_sel_n;
	assign tgt = port_select_lines;
	// trailing edge commits the transfer, so held strobes act once
	assign wr_edge = sel & wr_n & wr_d_ff;
	assign rd_edge = sel & rd_n & rd_d_ff;
	assign rd_act = sel & ~rd_n & wr_n & (tgt != ITP_SEL_CW);
	assign sc = data_in[ITP_CW_SC_LSB+1:ITP_CW_SC_LSB];

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_d_ff <= 1'b0;
			rd_d_ff <= 1'b0;
		end else begin
			// strobes only tracked while selected
			wr_d_ff <= sel & ~wr_n;
			rd_d_ff <= sel & ~rd_n & (tgt != ITP_SEL_CW);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < ITP_NUM_CNT; gi++) begin : g_cnt
			localparam logic [1:0] SLOT = 2'(gi);
			logic is_cw;
			assign is_cw = wr_edge && tgt == ITP_SEL_CW && sc == SLOT;
			assign cw_wr[gi] = is_cw && data_in[ITP_CW_RW_LSB+1:ITP_CW_RW_LSB] != ITP_BA_LATCH;
			assign latch_cmd[gi] = is_cw && data_in[ITP_CW_RW_LSB+1:ITP_CW_RW_LSB] == ITP_BA_LATCH;
			assign load_en[gi] = wr_edge && tgt == SLOT && !(fmt_ff[gi] == ITP_BA_WORD && !wr_hi_ff[gi]);
			always_comb begin
				case (fmt_ff[gi])
				ITP_BA_LSB: load_val[gi] = {8'h00, data_in};
				ITP_BA_MSB: load_val[gi] = {data_in, 8'h00};
				default: load_val[gi] = {data_in, lo_hold_ff[gi]};
				endcase
			end
			// byte pointers only move on selected strobes
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					fmt_ff[gi] <= ITP_BA_LSB;
					wr_hi_ff[gi] <= 1'b0;
					rd_hi_ff[gi] <= 1'b0;
					lo_hold_ff[gi] <= 8'h00;
				end else if (cw_wr[gi]) begin
					fmt_ff[gi] <= data_in[ITP_CW_RW_LSB+1:ITP_CW_RW_LSB];
					wr_hi_ff[gi] <= 1'b0;
					rd_hi_ff[gi] <= 1'b0;
				end else begin
					if (wr_edge && tgt == SLOT && fmt_ff[gi] == ITP_BA_WORD) begin
						wr_hi_ff[gi] <= ~wr_hi_ff[gi];
						if (!wr_hi_ff[gi])
							lo_hold_ff[gi] <= data_in;
					end
					if (rd_edge && tgt == SLOT && fmt_ff[gi] == ITP_BA_WORD)
						rd_hi_ff[gi] <= ~rd_hi_ff[gi];
				end
			end
			itp_counter u_cnt (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.cw_wr(cw_wr[gi]),
				.cw_val(data_in[5:0]),
				.load_en(load_en[gi]),
				.load_val(load_val[gi]),
				.latch_cmd(latch_cmd[gi]),
				.tick_in(counter_tick_inputs[gi]),
				.gate_in(count_enable_inputs[gi]),
				.count_view(view[gi]),
				.wave_out(wave[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// read path: byte chosen by format and read pointer
	always_comb begin
		nxt_data = ITP_RD_RST;
		if (tgt != ITP_SEL_CW) begin
			if (fmt_ff[tgt] == ITP_BA_MSB || (fmt_ff[tgt] == ITP_BA_WORD && rd_hi_ff[tgt]))
				nxt_data = view[tgt][15:8];
			else
				nxt_data = view[tgt][7:0];
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			data_out <= ITP_RD_RST;
			data_oe <= 1'b0;
			timer_wave_pins <= '0;
		end else begin
			data_out <= nxt_data;
			data_oe <= rd_act;
			timer_wave_pins <= wave;
		end
	end
endmodule

// File: core/itp_pkg.sv
package itp_pkg;
	localparam int ITP_DATA_W = 8;
	localparam int ITP_CNT_W = 16;
	localparam int ITP_NUM_CNT = 3;
	// port select decode
	localparam logic [1:0] ITP_SEL_CW = 2'h3;
	// control word field positions
	localparam int ITP_CW_SC_LSB = 6;
	localparam int ITP_CW_RW_LSB = 4;
	localparam int ITP_CW_MODE_LSB = 1;
	localparam int ITP_CW_BCD_BIT = 0;
	// byte access format encodings
	localparam logic [1:0] ITP_BA_LATCH = 2'h0;
	localparam logic [1:0] ITP_BA_LSB = 2'h1;
	localparam logic [1:0] ITP_BA_MSB = 2'h2;
	localparam logic [1:0] ITP_BA_WORD = 2'h3;
	// reset values
	localparam logic [15:0] ITP_CNT_RST = 16'h0000;
	localparam logic [5:0] ITP_CW_RST = 6'h00;
	localparam logic [7:0] ITP_RD_RST = 8'h00;
	// counter phase states
	typedef enum logic [2:0] {
		ITP_IDLE = 3'b001,
		ITP_ARMED = 3'b010,
		ITP_RUN = 3'b100
	} itp_phase_t;
endpackage

// File: tb/interval_timer_host_port_tb.sv
`timescale 1ns/1ps
module interval_timer_host_port_tb;
	import itp_pkg::*;
	typedef struct {logic [1:0] a; logic [7:0] d;} itp_row_t;
	logic ref_clk = 0, nrst = 0, cs_n, rd_n, wr_n, data_oe;
	logic [1:0] adr;
	logic [7:0] dq, data_out;
	logic [2:0] tick = 0, gate = 0, wave;
	logic [8:0] r;
	int fails = 0, checks_done = 0, cyc = 0;
	itp_row_t rows[3] = '{'{2'h0, 8'h5a}, '{2'h1, 8'ha5}, '{2'h2, 8'hff}};
	itp_host_port dut_u (.ref_clk(ref_clk), .nrst(nrst), .chip_sel_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.port_select_lines(adr), .data_in(dq), .data_out(data_out), .data_oe(data_oe),
		.counter_tick_inputs(tick), .count_enable_inputs(gate), .timer_wave_pins(wave));
	itp_host_model h_u (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .adr(adr), .dq(dq),
		.bus({data_oe, data_out}));
	initial forever #12.5 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge ref_clk) tick[0] <= 1'b1;
			repeat (2) @(posedge ref_clk);
			tick[0] <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fails++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		@(negedge ref_clk) chk("reset", 12'h0, {data_oe, data_out, wave});
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			h_u.put(ITP_SEL_CW, {2'(i), ITP_BA_LSB, 4'h0}, 1'b0);
			h_u.put(rows[i].a, rows[i].d, 1'b0);
			h_u.get(rows[i].a, r);
			chk("row read", {4'h1, rows[i].d}, r);
		end
		$display("test rows done");
		h_u.put(2'h1, 8'h33, 1'b1);
		h_u.get(2'h1, r);
		chk("deselected write", 12'h1a5, r);
		h_u.get(ITP_SEL_CW, r);
		chk("control read", 12'h0, r[8]);
		h_u.put(ITP_SEL_CW, {2'h2, ITP_BA_WORD, 4'h0}, 1'b0);
		h_u.put(2'h2, 8'h34, 1'b0);
		h_u.put(2'h2, 8'h12, 1'b0);
		h_u.get(2'h2, r);
		chk("word low", 12'h134, r);
		h_u.get(2'h2, r);
		chk("word high", 12'h112, r);
		h_u.put(ITP_SEL_CW, {2'h1, ITP_BA_MSB, 4'h0}, 1'b0);
		h_u.put(2'h1, 8'h77, 1'b0);
		h_u.put(ITP_SEL_CW, {2'h1, ITP_BA_LATCH, 4'h0}, 1'b0);
		h_u.get(2'h1, r);
		chk("latched high", 12'h177, r);
		h_u.put(ITP_SEL_CW, {2'h0, ITP_BA_LSB, 4'h0}, 1'b0);
		h_u.get(2'h0, r);
		// cleared element hidden: the held count shows instead
		chk("cleared count", 12'h15a, r);
		$display("test access done");
		// gate held low first, so ticks alone must not finish the count
		h_u.put(2'h0, 8'h02, 1'b0);
		pulse(6);
		chk("gate low wave", 12'h0, wave);
		@(posedge ref_clk) gate[0] <= 1'b1;
		pulse(6);
		chk("terminal wave", 12'h1, wave);
		// rate mode: one low tick per three counts, latch keeps the pre-reload count
		h_u.put(ITP_SEL_CW, {2'h0, ITP_BA_LSB, 3'h2, 1'b0}, 1'b0);
		h_u.put(2'h0, 8'h03, 1'b0);
		pulse(3);
		chk("rate low", 12'h0, wave);
		h_u.put(ITP_SEL_CW, {2'h0, ITP_BA_LATCH, 4'h0}, 1'b0);
		pulse(1);
		chk("rate high", 12'h1, wave);
		h_u.get(2'h0, r);
		chk("latched count", 12'h101, r);
		$display("test wave done");
		print_verdict();
	end
endmodule

// File: tb/itp_host_model.sv
`timescale 1ns/1ps
module itp_host_model (
	// system
	input wire logic ref_clk,
	// bus
	output logic cs_n,
	output logic rd_n,
	output logic wr_n,
	output logic [1:0] adr,
	output logic [7:0] dq,
	input wire logic [8:0] bus
);
	initial begin
		{cs_n, rd_n, wr_n, adr, dq} = '1;
	end
	// write: strobe low two edges, commit seen on the rising strobe
	task automatic put(input logic [1:0] a, input logic [7:0] d, input logic c);
		@(posedge ref_clk) {cs_n, wr_n, adr, dq} <= {c, 1'b0, a, d};
		repeat (2) @(posedge ref_clk);
		wr_n <= 1'b1;
		@(posedge ref_clk) cs_n <= 1'b1;
		dq <= ~d; // released bus shows no stale byte
	endtask
	task automatic get(input logic [1:0] a, output logic [8:0] v);
		@(posedge ref_clk) {cs_n, rd_n, adr} <= {2'b00, a};
		@(posedge ref_clk);
		@(negedge ref_clk) v = bus;
		@(posedge ref_clk) rd_n <= 1'b1;
		@(posedge ref_clk) cs_n <= 1'b1;
	endtask
endmodule

// File: tb/itp_host_port_monitor.sv
`timescale 1ns/1ps
module itp_host_port_monitor
	import itp_pkg::*;
(
	// system
	input wire logic ref_clk,
	input wire logic nrst,
	// bus
	input wire logic chip_sel_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [1:0] port_select_lines,
	input wire logic data_oe,
	// counter pins
	input wire logic [ITP_NUM_CNT-1:0] counter_tick_inputs,
	input wire logic [ITP_NUM_CNT-1:0] count_enable_inputs,
	input wire logic [ITP_NUM_CNT-1:0] timer_wave_pins
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_desel_float: assert property (chip_sel_n |=> !data_oe) else $error("bus driven while deselected");
	a_rd_idle: assert property (rd_n |=> !data_oe) else $error("bus driven without read");
	a_read_drive: assert property (!chip_sel_n && !rd_n && port_select_lines != ITP_SEL_CW |=> data_oe)
		else $error("no drive on read");
	a_oe_cause: assert property ($rose(data_oe) |-> $past(!chip_sel_n && !rd_n)) else $error("drive without access");
	a_rise_target: assert property ($rose(data_oe) |-> $past(port_select_lines) != ITP_SEL_CW)
		else $error("drive for control slot");
	a_oe_release: assert property ($fell(data_oe) |-> $past(rd_n || chip_sel_n || port_select_lines == ITP_SEL_CW))
		else $error("drive dropped early");
	a_cw_no_read: assert property (port_select_lines == ITP_SEL_CW |=> !data_oe) else $error("control read drove");
	// six quiet cycles let any tick pipeline settle before the waves must hold
	a_wave_quiet: assert property (($stable(counter_tick_inputs) && $stable(count_enable_inputs) && wr_n)[*6]
		|=> $stable(timer_wave_pins)) else $error("wave moved without cause");
endmodule
////////////////////////////////////////////////////////////////
bind itp_host_port itp_host_port_monitor mon_u (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.chip_sel_n(chip_sel_n),
	.rd_n(rd_n),
	.wr_n(wr_n),
	.port_select_lines(port_select_lines),
	.data_oe(data_oe),
	.counter_tick_inputs(counter_tick_inputs),
	.count_enable_inputs(count_enable_inputs),
	.timer_wave_pins(timer_wave_pins)
);
